// ### hw/mss_pkg.sv
// Shared constants and types of the measurement scan sequencer
package mss_pkg;
  // Clock and slot timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SLOT_TIME_NS  = 711000;
  localparam int unsigned DIODE_TIME_NS = 2130000;
  localparam int unsigned SLOT_CYC      = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DIODE_CYC     = DIODE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W       = 18;

  // Converter data
  localparam int unsigned CODE_W        = 8;
  localparam int unsigned ACC_W         = 12;
  localparam int unsigned AVG_SHIFT     = 4;
  localparam logic [4:0]  AVG_SAMPLES   = 5'h10;
  localparam logic [4:0]  BAT_SAMPLES   = 5'h01;
  localparam logic [7:0]  NOMINAL_CODE  = 8'hC0;

  // Channel indexes in scan order
  localparam int unsigned CH_W              = 5;
  localparam logic [4:0] CH_ANALOG_FIRST    = 5'h00;
  localparam logic [4:0] CH_PAIR_LO         = 5'h08;
  localparam logic [4:0] CH_PAIR_HI         = 5'h09;
  localparam logic [4:0] CH_PLUS5           = 5'h0A;
  localparam logic [4:0] CH_MINUS12         = 5'h0B;
  localparam logic [4:0] CH_PLUS12          = 5'h0C;
  localparam logic [4:0] CH_CORE_RAIL       = 5'h0D;
  localparam logic [4:0] CH_MAIN_RAIL       = 5'h0E;
  localparam logic [4:0] CH_STANDBY_RAIL    = 5'h0F;
  localparam logic [4:0] CH_BATTERY         = 5'h10;
  localparam logic [4:0] CH_LOCAL_TEMP      = 5'h11;
  localparam logic [4:0] CH_REMOTE_ONE      = 5'h12;
  localparam logic [4:0] CH_REMOTE_TWO      = 5'h13;
  localparam logic [4:0] CH_LAST            = 5'h13;

  // Value register addresses
  localparam int unsigned ADDR_W            = 5;
  localparam int unsigned MEM_DEPTH         = 32;
  localparam logic [4:0] ADDR_LOCAL_TEMP    = 5'h1F;

  typedef enum logic [1:0] {
    MSS_IDLE,
    MSS_START,
    MSS_SLOT,
    MSS_WRITE
  } mss_state_e;

  // Command to the analog front end
  typedef struct packed {
    logic [4:0] mux_sel;
    logic       remote_mode;
    logic       bat_leg_on;
  } mss_conv_cmd_s;

  localparam mss_conv_cmd_s CMD_RESET = '{5'h00, 1'b0, 1'b0};
endpackage

// ### hw/mss_value_ram.sv
// Channel value registers, one write port and a registered read port
`timescale 1ns/1ns
module mss_value_ram (
  // Clock
  input  wire logic                       clk,
  // Write side
  input  wire logic                       we,
  input  wire logic [mss_pkg::ADDR_W-1:0] waddr,
  input  wire logic [mss_pkg::CODE_W-1:0] wdata,
  // Read side
  input  wire logic [mss_pkg::ADDR_W-1:0] raddr,
  output      logic [mss_pkg::CODE_W-1:0] rdata_q
);
  import mss_pkg::*;

  logic [CODE_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end
endmodule

// ### hw/mss_scan_seq.sv
// Round-robin scan, averaging and result storage for the monitor converter
// How it works
// - voltage results are unsigned 8-bit codes up to 255, temperature codes are signed.
// - attenuated supply inputs read code 192 at their nominal rail.
// - one analog or local temperature sample is taken per 711 us slot.
// - analog and local channels average 16 samples into one reading.
// - a remote diode sample takes 2.13 ms and 16 of them are averaged.
// - channels are visited in fixed round-robin order while enabled.
// - the battery channel takes one sample per scan with no averaging.
// - the battery attenuator leg is connected only in the battery slot.
// - a full scan takes about 240 ms (about 228 ms in pair analog mode) with one battery slot inside it.
// - the scan covers all three board rails and die temperature as well.
// - one input pair is either two analog inputs or a second diode.
// - the pair mode follows bit 3 of configuration register 00h.
// - the averaged local temperature goes to value register 1Fh.
`timescale 1ns/1ns
module mss_scan_seq #(
  parameter int unsigned SLOT_CYCLES  = mss_pkg::SLOT_CYC,
  parameter int unsigned DIODE_CYCLES = mss_pkg::DIODE_CYC
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Control
  input  wire logic                       conv_enable,
  input  wire logic                       pair_analog_mode,
  // Converter
  input  wire logic [mss_pkg::CODE_W-1:0] conv_code,
  output      mss_pkg::mss_conv_cmd_s     conv_cmd_q,
  output      logic                       conv_start_q,
  // Status
  output      logic                       busy_q,
  output      logic                       scan_done_q,
  // Value read port
  input  wire logic [mss_pkg::ADDR_W-1:0] rd_addr,
  output      logic [mss_pkg::CODE_W-1:0] rd_data_q
);
  import mss_pkg::*;

  mss_state_e         state_q;
  logic [CH_W-1:0]    chan_q;
  logic [CH_W-1:0]    chan_d;
  logic [TIMER_W-1:0] timer_q;
  logic [4:0]         samp_q;
  logic [4:0]         samp_need;
  logic [ACC_W-1:0]   acc_q;
  logic [ACC_W-1:0]   code_ext;
  logic               is_remote;
  logic               is_temp;
  logic               slot_end;
  logic               mem_we;
  logic [ADDR_W-1:0]  mem_addr;
  logic [CODE_W-1:0]  mem_wdata;
  logic [4:0]         nslots_q;

  assign is_remote = (chan_q == CH_REMOTE_ONE) || (chan_q == CH_REMOTE_TWO);
  assign is_temp   = is_remote || (chan_q == CH_LOCAL_TEMP);
  assign samp_need = (chan_q == CH_BATTERY) ? BAT_SAMPLES : AVG_SAMPLES;
  assign slot_end  = (state_q == MSS_SLOT) && (timer_q == '0);
  // temperature codes are signed, voltages unsigned
  assign code_ext  = is_temp ? {{(ACC_W-CODE_W){conv_code[CODE_W-1]}},
                                conv_code}
                             : {{(ACC_W-CODE_W){1'b0}}, conv_code};

  // Next channel in the fixed order, skipping what the pair mode excludes
  // full order, mode input
  always_comb begin
    chan_d = (chan_q == CH_LAST) ? CH_ANALOG_FIRST : chan_q + 5'h01;
    // pair inputs only scanned in analog mode
    if (!pair_analog_mode && (chan_d == CH_PAIR_LO)) begin
      chan_d = CH_PLUS5;
    end
    // analog mode drops the second diode slot
    if (pair_analog_mode && (chan_d == CH_REMOTE_TWO)) begin
      chan_d = CH_ANALOG_FIRST;
    end
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= MSS_IDLE;
    end else begin
      unique case (state_q)
        MSS_IDLE: begin
          if (conv_enable) begin
            state_q <= MSS_START;
          end
        end
        MSS_START: begin
          state_q <= MSS_SLOT;
        end
        MSS_SLOT: begin
          if (slot_end) begin
            state_q <= (samp_q + 5'h01 == samp_need) ? MSS_WRITE : MSS_START;
          end
        end
        MSS_WRITE: begin
          // Stopping only at channel boundaries keeps averages whole
          state_q <= conv_enable ? MSS_START : MSS_IDLE;
        end
      endcase
    end
  end

  // channel pointer advances after each result
  always_ff @(posedge clk) begin
    if (reset) begin
      chan_q <= CH_ANALOG_FIRST;
    end else if (state_q == MSS_WRITE) begin
      chan_q <= chan_d;
    end
  end

  // slot timer, longer for remote diodes
  always_ff @(posedge clk) begin
    if (reset) begin
      timer_q <= '0;
    end else if (state_q == MSS_START) begin
      timer_q <= is_remote ? TIMER_W'(DIODE_CYCLES - 1)
                           : TIMER_W'(SLOT_CYCLES - 1);
    end else if (state_q == MSS_SLOT && timer_q != '0) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  // accumulate samples of the current channel
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q  <= '0;
      samp_q <= '0;
    end else if (state_q == MSS_WRITE) begin
      acc_q  <= '0;
      samp_q <= '0;
    end else if (slot_end) begin
      acc_q  <= acc_q + code_ext;
      samp_q <= samp_q + 5'h01;
    end
  end

  // Front end command; held stable for the whole slot
  always_ff @(posedge clk) begin
    if (reset) begin
      conv_cmd_q <= CMD_RESET;
    end else if (state_q == MSS_START) begin
      conv_cmd_q.mux_sel     <= chan_q;
      conv_cmd_q.remote_mode <= is_remote;
      // leg switched in for the battery slot only
      conv_cmd_q.bat_leg_on  <= (chan_q == CH_BATTERY);
    end else if (slot_end || state_q != MSS_SLOT) begin
      // Drop at slot end so the leg is already off in the write cycle
      conv_cmd_q.bat_leg_on  <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      conv_start_q <= 1'b0;
      busy_q       <= 1'b0;
    end else begin
      conv_start_q <= (state_q == MSS_START);
      busy_q       <= (state_q != MSS_IDLE);
    end
  end

  // one pulse per completed scan, on wrap to the first channel
  always_ff @(posedge clk) begin
    if (reset) begin
      scan_done_q <= 1'b0;
    end else begin
      scan_done_q <= (state_q == MSS_WRITE) && (chan_d == CH_ANALOG_FIRST);
    end
  end

  // one write with the finished average
  assign mem_we    = (state_q == MSS_WRITE);
  // local temperature lands at its fixed address
  assign mem_addr  = (chan_q == CH_LOCAL_TEMP) ? ADDR_LOCAL_TEMP : chan_q;
  // codes stored unscaled, nominal rails read NOMINAL_CODE
  assign mem_wdata = (chan_q == CH_BATTERY) ? acc_q[CODE_W-1:0]
                                            : acc_q[ACC_W-1:AVG_SHIFT];

  mss_value_ram u_ram (
    .clk     (clk),
    .we      (mem_we),
    .waddr   (mem_addr),
    .wdata   (mem_wdata),
    .raddr   (rd_addr),
    .rdata_q (rd_data_q)
  );

  // Slots seen per channel, for checking only
  always_ff @(posedge clk) begin
    if (reset || state_q == MSS_WRITE) begin
      nslots_q <= '0;
    end else if (state_q == MSS_START) begin
      nslots_q <= nslots_q + 5'h01;
    end
  end

  chk_bat_leg_slot: assert property (
    @(posedge clk) disable iff (reset)
    conv_cmd_q.bat_leg_on |->
      (conv_cmd_q.mux_sel == CH_BATTERY) && (state_q == MSS_SLOT))
    else $error("battery leg on outside battery slot");

  chk_avg_count: assert property (
    @(posedge clk) disable iff (reset)
    (mem_we && chan_q != CH_BATTERY) |-> (nslots_q == AVG_SAMPLES))
    else $error("average written with wrong sample count");

  chk_bat_single: assert property (
    @(posedge clk) disable iff (reset)
    (mem_we && chan_q == CH_BATTERY) |-> (nslots_q == BAT_SAMPLES))
    else $error("battery not single sample");

  chk_write_once: assert property (
    @(posedge clk) disable iff (reset)
    mem_we |=> !mem_we)
    else $error("value written twice in a row");

  chk_local_addr: assert property (
    @(posedge clk) disable iff (reset)
    (mem_we && chan_q == CH_LOCAL_TEMP) |-> (mem_addr == 5'h1F))
    else $error("local temperature at wrong address");

  chk_pair_mode: assert property (
    @(posedge clk) disable iff (reset)
    (state_q == MSS_WRITE && pair_analog_mode) |=>
      (chan_q != CH_REMOTE_TWO))
    else $error("second diode scanned in analog mode");

  chk_slot_start: assert property (
    @(posedge clk) disable iff (reset)
    (state_q == MSS_START) |=> conv_start_q ##1 !conv_start_q)
    else $error("slot start pulse malformed");

  chk_round_robin: assert property (
    @(posedge clk) disable iff (reset)
    (state_q == MSS_WRITE) |=> (chan_q != $past(chan_q)))
    else $error("channel did not advance");

  chk_scan_wrap: assert property (
    @(posedge clk) disable iff (reset)
    scan_done_q |-> (chan_q == CH_ANALOG_FIRST))
    else $error("scan done without wrap");
endmodule

// ### dv/mss_scan_seq_tb_top.sv
// Self-checking bench for the measurement scan sequencer
`timescale 1ns/1ns
module mss_scan_seq_tb_top;
  import mss_pkg::*;
  localparam int unsigned SLOT  = 4;
  localparam int unsigned DIODE = 8;
  logic                  clk;
  logic                  reset;
  logic                  conv_enable;
  logic                  pair_analog_mode;
  logic [CODE_W-1:0]     conv_code;
  mss_conv_cmd_s         conv_cmd_q;
  logic                  conv_start_q;
  logic                  busy_q;
  logic                  scan_done_q;
  logic [ADDR_W-1:0]     rd_addr;
  logic [CODE_W-1:0]     rd_data_q;
  logic                  kk = 1'b0;
  logic [7:0]            bat_code;
  int                    num_errors;
  int                    checks_done;

  mss_scan_seq #(.SLOT_CYCLES(SLOT), .DIODE_CYCLES(DIODE)) dut (
    .clk(clk), .reset(reset), .conv_enable(conv_enable),
    .pair_analog_mode(pair_analog_mode), .conv_code(conv_code),
    .conv_cmd_q(conv_cmd_q), .conv_start_q(conv_start_q), .busy_q(busy_q),
    .scan_done_q(scan_done_q), .rd_addr(rd_addr), .rd_data_q(rd_data_q));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Codes alternate base and base+1 so a floor average returns the base
  function automatic logic [7:0] base_of(logic [4:0] ch);
    return (ch >= CH_LOCAL_TEMP) ? 8'hF6 : {ch, 3'h0};
  endfunction

  always @(posedge clk) if (conv_start_q === 1'b1) kk <= ~kk;
  always @(negedge clk) conv_code <= base_of(conv_cmd_q.mux_sel) + {7'h00, kk};

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [4:0] nxt(logic [4:0] c);
    if (c == 5'h07 && !pair_analog_mode) return CH_PLUS5;
    if (c == CH_REMOTE_ONE && pair_analog_mode) return CH_ANALOG_FIRST;
    if (c == CH_LAST) return CH_ANALOG_FIRST;
    return c + 5'h01;
  endfunction

  // Follows one whole scan, checking order, spacing and the battery leg
  task automatic run_scan();
    logic [4:0] cur;
    int n;
    int gap;
    int bcnt;
    int i;
    // A scan already under way is skipped so tracking starts at channel 0
    if (busy_q === 1'b1) begin
      for (i = 0; i < 20000 && scan_done_q !== 1'b1; i++) @(negedge clk);
      if (i == 20000) begin
        num_errors++;
        conclude();
      end
    end
    cur = CH_LAST;
    n = 16;
    gap = 0;
    bcnt = 0;
    for (i = 0; i < 20000; i++) begin
      @(negedge clk);
      gap++;
      if (conv_start_q === 1'b1) begin
        if (n == ((cur == CH_BATTERY) ? 1 : 16)) begin
          cur = nxt(cur);
          n = 0;
        end else begin
          chk("slot gap", (cur >= CH_REMOTE_ONE) ? DIODE + 1 : SLOT + 1,
              16'(gap));
        end
        chk("mux_sel", {11'h0, cur}, {11'h0, conv_cmd_q.mux_sel});
        chk("remote mode", {15'h0, cur >= CH_REMOTE_ONE},
            {15'h0, conv_cmd_q.remote_mode});
        n++;
        gap = 0;
      end
      if (conv_cmd_q.bat_leg_on === 1'b1) begin
        chk("leg channel", {11'h0, CH_BATTERY},
            {11'h0, conv_cmd_q.mux_sel});
        bcnt++;
        bat_code = conv_code;
      end
      if (scan_done_q === 1'b1) break;
    end
    if (i == 20000) begin
      num_errors++;
      conclude();
    end
    chk("last channel", pair_analog_mode ? CH_REMOTE_ONE : CH_LAST,
        {11'h0, cur});
    chk("last samples", 16, 16'(n));
    chk("battery cycles", SLOT, 16'(bcnt));
    $display("scan done, pair analog mode %0b", pair_analog_mode);
  endtask

  // Reads every value written in the scan and compares with the average, or for the battery with its single sampled code
  task automatic check_values(logic skip_pair);
    logic [4:0] ch;
    logic [7:0] exp;
    for (int c = 0; c <= 19; c++) begin
      ch = 5'(c);
      if (skip_pair && (ch == CH_PAIR_LO || ch == CH_PAIR_HI)) continue;
      exp = (ch == CH_BATTERY) ? bat_code : base_of(ch);
      rd_addr = (ch == CH_LOCAL_TEMP) ? ADDR_LOCAL_TEMP : ch;
      @(negedge clk);
      chk("value", {8'h0, exp}, {8'h0, rd_data_q});
    end
    $display("values checked");
  endtask

  task automatic stop_scan();
    int i;
    conv_enable = 1'b0;
    for (i = 0; i < 2000 && busy_q !== 1'b0; i++) @(negedge clk);
    chk("busy after stop", 0, {15'h0, busy_q});
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (conv_start_q !== 1'b0) chk("idle start", 0, 1);
    end
    $display("stop checked");
  endtask

  initial begin
    reset = 1'b1;
    conv_enable = 1'b0;
    pair_analog_mode = 1'b0;
    rd_addr = 5'h00;
    bat_code = 8'h00;
    num_errors = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk("reset state", 0, {7'h0, conv_cmd_q, conv_start_q, busy_q});
    conv_enable = 1'b1;
    run_scan();
    check_values(1'b1);
    pair_analog_mode = 1'b1;
    run_scan();
    check_values(1'b0);
    stop_scan();
    conclude();
  end
endmodule
